//--- include/lcd_psc_regs.svh
// constants of the lcd power-save and contrast control block
`ifndef LCD_PSC_REGS_SVH
`define LCD_PSC_REGS_SVH
// ----------------------------------------------------------------
// instruction opcodes (upper seven bits, d0 is the argument; contrast upper four bits, reset whole byte)
// ----------------------------------------------------------------
`define OPC_DISP_ONOFF 7'h57
`define OPC_STATIC 7'h52
`define OPC_ADC 7'h50
`define OPC_PWR 7'h12
`define OPC_DRV 7'h16
`define OPC_CONTRAST_HI 4'h8
`define OPC_RESET 8'hE2
// ----------------------------------------------------------------
// reset values and ratio constants
// ----------------------------------------------------------------
`define CONTRAST_RST 4'h0
`define REF_BASE_NUM 8'h87
`define REF_DEN 8'h96
`endif

//--- include/lcd_psc_pkg.sv
// types of the lcd power-save and contrast control block
`default_nettype none
package lcd_psc_pkg;
  typedef enum logic [1:0] {
    ps_run,
    ps_save
  } ps_state_e;
  typedef struct packed {
    logic osc_en;
    logic supply_en;
    logic booster_en;
    logic drive_en;
    logic outputs_vdd;
    logic seg_reverse;
  } power_ctrl_s;
  typedef struct packed {
    logic disp_on;
    logic whole_on;
    logic inverse;
    logic adc;
    logic pwr_on;
    logic drv_on;
    logic [3:0] contrast;
  } cfg_s;
endpackage
`default_nettype wire

//--- rtl/sync3.sv
// three-stage input synchroniser that accepts a change once stages agree
`default_nettype none
module sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire [WIDTH-1:0] agree = ~(s2 ^ s3);

  // shift chain and stable output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (agree & s3) | (~agree & dout);
    end
  end
endmodule
`default_nettype wire

//--- rtl/lcd_psc_ctrl.sv
// power-save, driver output, segment order and contrast control of an lcd driver
//
// What this block does
// [R1] enter power save when whole-display-on and display-off hold, either order
// [R2] in power save stop oscillator and internal supply circuits
// [R3] in power save stop drive waveform, hold all outputs at vdd
// [R4] power save keeps memory and configuration exactly as before
// [R5] save starts after whole-on instruction, ends after whole-on-off instruction
// [R6] host may issue display-on any time after whole-on cancel completes
// [R7] no drive waveform until driver-outputs-on instruction executed
// [R8] only driver-outputs-off instruction switches driver outputs off
// [R9] segment-order instruction reverses column to segment mapping
// [R10] booster runs only while oscillator or external clock runs
// [R11] 4-bit contrast n selects reference (135+n)/150 of supply
// [R12] host enables internal supply before contrast takes effect
// [R13] whole-display-on forces pixels on, memory untouched
// [R14] instruction interface stays alive during power save
`default_nettype none
`include "lcd_psc_regs.svh"
module lcd_psc_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // instruction port from the mpu interface (asynchronous strobe)
  input wire logic instr_stb,
  input wire logic [7:0] instr_data,
  // external booster clock present
  input wire logic ext_clk_present,
  // analog and driver control
  output lcd_psc_pkg::power_ctrl_s pwr,
  output logic [3:0] contrast_step_register,
  output logic [7:0] ref_num,
  output logic [7:0] ref_den,
  output logic pixel_force_on,
  output logic pixel_invert,
  output logic in_power_save
);
  // ----------------------------------------------------------------
  // reset release and input synchronisation
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  wire rst_n = rst_pipe[1];

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end

  logic [8:0] sync_out;
  logic ext_clk_s;
  logic stb_q;
  logic [7:0] data_s;
  logic stb_s;

  // strobe and data cross from the mpu side; data is stable around the strobe
  sync3 #(.WIDTH(9)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({instr_stb, instr_data}),
    .dout(sync_out)
  );
  assign stb_s = sync_out[8];
  assign data_s = sync_out[7:0];

  sync3 #(.WIDTH(1)) u_sync_clk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(ext_clk_present),
    .dout(ext_clk_s)
  );

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  function automatic logic op_is(input logic [7:0] d, input logic [6:0] opc);
    op_is = (d[7:1] == opc);
  endfunction

  // rising strobe marks one completed instruction
  wire exec = stb_s & ~stb_q;
  wire dec_disp = exec & op_is(data_s, `OPC_DISP_ONOFF);
  wire dec_static = exec & op_is(data_s, `OPC_STATIC);
  wire dec_adc = exec & op_is(data_s, `OPC_ADC);
  wire dec_pwr = exec & op_is(data_s, `OPC_PWR);
  wire dec_drv = exec & op_is(data_s, `OPC_DRV);
  wire dec_con = exec & (data_s[7:4] == `OPC_CONTRAST_HI);
  wire dec_rst = exec & (data_s == `OPC_RESET);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  lcd_psc_pkg::cfg_s cfg;
  lcd_psc_pkg::cfg_s next_cfg;

  // each instruction updates only its own field, so power save alters nothing
  always_comb begin
    next_cfg = cfg;
    // [R14] decode active in save
    if (dec_disp) begin
      next_cfg.disp_on = data_s[0];
    end
    // [R13] whole on flag
    if (dec_static) begin
      next_cfg.whole_on = data_s[0];
    end
    // [R9] segment order select
    if (dec_adc) begin
      next_cfg.adc = data_s[0];
    end
    if (dec_pwr) begin
      next_cfg.pwr_on = data_s[0];
    end
    // [R7] [R8] driver output switch
    if (dec_drv) begin
      next_cfg.drv_on = data_s[0];
    end
    // [R11] contrast step load
    if (dec_con) begin
      next_cfg.contrast = data_s[3:0];
    end
    if (dec_rst) begin
      next_cfg.contrast = `CONTRAST_RST;
    end
  end

  // configuration storage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
      stb_q <= 1'h0;
    end else begin
      cfg <= next_cfg;
      stb_q <= stb_s;
    end
  end

  // ----------------------------------------------------------------
  // power-save state machine
  // ----------------------------------------------------------------
  lcd_psc_pkg::ps_state_e state;
  lcd_psc_pkg::ps_state_e next_state;

  // [R1] [R5] save follows the combined condition after each instruction
  always_comb begin
    case (state)
      lcd_psc_pkg::ps_run: begin
        if (next_cfg.whole_on && !next_cfg.disp_on) begin
          next_state = lcd_psc_pkg::ps_save;
        end else begin
          next_state = lcd_psc_pkg::ps_run;
        end
      end
      lcd_psc_pkg::ps_save: begin
        if (!next_cfg.whole_on || next_cfg.disp_on) begin
          next_state = lcd_psc_pkg::ps_run;
        end else begin
          next_state = lcd_psc_pkg::ps_save;
        end
      end
      default: begin
        next_state = lcd_psc_pkg::ps_run;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= lcd_psc_pkg::ps_run;
    end else begin
      state <= next_state;
    end
  end

  wire saving = (state == lcd_psc_pkg::ps_save);

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // [R2] oscillator and supply gated off in save
  wire osc_on = ~saving;
  wire supply_on = cfg.pwr_on & ~saving;
  // [R10] booster needs a running clock
  wire boost_on = supply_on & (osc_on | ext_clk_s);
  // [R3] [R7] drive only with outputs on and not saving
  wire drive_on = cfg.drv_on & ~saving;
  // [R11] reference numerator is 135 plus the step
  wire [7:0] next_ref = `REF_BASE_NUM + {4'h0, cfg.contrast};

  // registered control outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr <= '0;
      contrast_step_register <= `CONTRAST_RST;
      ref_num <= `REF_BASE_NUM;
      pixel_force_on <= 1'h0;
      pixel_invert <= 1'h0;
      in_power_save <= 1'h0;
    end else begin
      pwr.osc_en <= osc_on;
      pwr.supply_en <= supply_on;
      pwr.booster_en <= boost_on;
      pwr.drive_en <= drive_on;
      pwr.outputs_vdd <= ~drive_on;
      pwr.seg_reverse <= cfg.adc;
      contrast_step_register <= cfg.contrast;
      ref_num <= next_ref;
      pixel_force_on <= cfg.whole_on;
      pixel_invert <= cfg.inverse;
      in_power_save <= saving;
    end
  end

  assign ref_den = `REF_DEN;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // [R1] save follows condition
  chk_save_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg.whole_on && !cfg.disp_on) |-> ##1 in_power_save) // [R1]
    else $error("power save not entered");
  // [R2] supply off in save
  chk_osc_halt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_power_save |-> !pwr.osc_en && !pwr.supply_en) // [R2]
    else $error("oscillator or supply running in save");
  // [R3] outputs at vdd in save
  chk_out_vdd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_power_save |-> pwr.outputs_vdd && !pwr.drive_en) // [R3]
    else $error("drive active in save");
  // [R4] config untouched on entry
  chk_cfg_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(saving) |-> $stable(cfg.contrast) && $stable(cfg.adc)) // [R4]
    else $error("configuration changed on save entry");
  // [R5] release after whole-on off
  chk_save_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (saving && dec_static && !data_s[0]) |=> !saving) // [R5]
    else $error("power save not released");
  // [R7] no drive before outputs on
  chk_drv_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.drv_on |=> !pwr.drive_en) // [R7]
    else $error("drive without outputs on");
  // [R8] outputs off only by instruction
  chk_drv_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg.drv_on && !dec_drv) |=> cfg.drv_on) // [R8]
    else $error("outputs dropped without instruction");
  // [R9] order follows select
  chk_seg_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dec_adc |-> ##2 (pwr.seg_reverse == $past(data_s[0], 2))) // [R9]
    else $error("segment order wrong");
  // [R10] booster needs clock
  chk_boost_clk: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwr.booster_en |-> (pwr.osc_en || $past(ext_clk_s))) // [R10]
    else $error("booster without clock");
  // [R11] reference numerator
  chk_ref_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dec_con |-> ##2 (ref_num == `REF_BASE_NUM + {4'h0, $past(data_s[3:0], 2)})) // [R11]
    else $error("reference level wrong");
  // [R13] whole-on forces pixels
  chk_force_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (dec_static && data_s[0]) |-> ##2 pixel_force_on) // [R13]
    else $error("pixels not forced");
  // [R14] decode alive in save
  chk_if_alive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (saving && dec_con) |=> (cfg.contrast == $past(data_s[3:0]))) // [R14]
    else $error("instruction lost in save");
  // [R3] drive and vdd level exclusive
  chk_drive_vdd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwr.drive_en |-> !pwr.outputs_vdd) // [R3]
    else $error("drive waveform with outputs at vdd");
  // [R5] save kept by other instructions
  chk_save_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (saving && !dec_static && !dec_disp) |=> saving) // [R5]
    else $error("power save left without release");
  // [R5] display on also ends save
  chk_save_disp_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (saving && dec_disp && data_s[0]) |=> !saving) // [R5]
    else $error("power save kept after display on");
  // [R10] booster only with supply
  chk_boost_supply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwr.booster_en |-> pwr.supply_en) // [R10]
    else $error("booster without supply");
  // [R11] reference tracks step
  chk_ref_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ref_num == (`REF_BASE_NUM + {4'h0, contrast_step_register})) // [R11]
    else $error("reference and step disagree");
  // [R13] pixel force follows instruction
  chk_force_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dec_static |-> ##2 (pixel_force_on == $past(data_s[0], 2))) // [R13]
    else $error("pixel force level wrong");

  cov_save_enter: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(saving));
  cov_save_leave: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(saving));
  cov_drive_on: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(pwr.drive_en));
  cov_save_step: cover property (@(posedge clk_sys) disable iff (!rst_n) saving && dec_con);
  cov_contrast_max: cover property (@(posedge clk_sys) disable iff (!rst_n)
    contrast_step_register == 4'hF);
endmodule
`default_nettype wire

//--- verification/mpu_model.sv
// instruction-issuing mpu model for the lcd power-save block
`default_nettype none
module mpu_model (
  // clock
  input wire logic clk_sys,
  // instruction port
  output logic instr_stb,
  output logic [7:0] instr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    instr_stb = 1'b0;
    instr_data = 8'h00;
  end
  // one byte: data first, strobe high then low six clocks each
  // host sequencing is left to the caller
  task automatic send(input logic [7:0] op);
    @(posedge clk_sys);
    #1 instr_data = op;
    @(posedge clk_sys);
    #1 instr_stb = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 instr_stb = 1'b0;
    repeat (6) @(posedge clk_sys);
    // released bus shows the inverse of the last byte
    #1 instr_data = ~op;
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking testbench of the lcd power-save and contrast block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, arst_n, ext_clk_present, instr_stb;
  logic [7:0] instr_data, ref_num, ref_den;
  logic [3:0] contrast_step_register;
  lcd_psc_pkg::power_ctrl_s pwr;
  logic pixel_force_on, pixel_invert, in_power_save;
  int failures, samples_checked;

  lcd_psc_ctrl u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .instr_stb(instr_stb),
    .instr_data(instr_data), .ext_clk_present(ext_clk_present), .pwr(pwr),
    .contrast_step_register(contrast_step_register), .ref_num(ref_num),
    .ref_den(ref_den), .pixel_force_on(pixel_force_on), .pixel_invert(pixel_invert),
    .in_power_save(in_power_save));
  mpu_model u_mpu (.clk_sys(clk_sys), .instr_stb(instr_stb), .instr_data(instr_data));

  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // power state and the gating that goes with it
  task automatic chk_ps(input logic exp);
    chk("in_power_save", {7'h00, exp}, {7'h00, in_power_save});
    if (exp) begin
      chk("pwr gating", 8'h01, {3'h0, pwr.osc_en, pwr.supply_en, pwr.booster_en,
        pwr.drive_en, pwr.outputs_vdd});
    end else begin
      chk("osc_en", 8'h01, {7'h00, pwr.osc_en});
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("contrast", 8'h00, {4'h0, contrast_step_register});
    chk("ref_num", 8'h87, ref_num);
    chk("ref_den", 8'h96, ref_den);
    chk("drive_en", 8'h00, {7'h00, pwr.drive_en});
    chk("outputs_vdd", 8'h01, {7'h00, pwr.outputs_vdd});
    chk("supply_en", 8'h00, {7'h00, pwr.supply_en});
    chk("pixel_invert", 8'h00, {7'h00, pixel_invert});
    chk_ps(1'b0);
    $display("reset values done");
  endtask
  // supply first, every contrast code, then the reset instruction
  task automatic t_contrast;
    u_mpu.send(8'h25);
    chk("supply_en", 8'h01, {7'h00, pwr.supply_en});
    chk("booster_en", 8'h01, {7'h00, pwr.booster_en});
    for (int n = 0; n < 16; n++) begin
      u_mpu.send(8'h80 | 8'(n));
      chk("contrast", 8'(n), {4'h0, contrast_step_register});
      chk("ref_num", 8'h87 + 8'(n), ref_num);
    end
    u_mpu.send(8'hE2);
    chk("contrast", 8'h00, {4'h0, contrast_step_register});
    $display("contrast steps done");
  endtask
  task automatic t_adc;
    u_mpu.send(8'hA1);
    chk("seg_reverse", 8'h01, {7'h00, pwr.seg_reverse});
    u_mpu.send(8'hA0);
    chk("seg_reverse", 8'h00, {7'h00, pwr.seg_reverse});
    u_mpu.send(8'hA1);
    $display("segment order done");
  endtask
  // entry in both orders, state kept, interface alive in save
  task automatic t_save;
    u_mpu.send(8'h8A);
    u_mpu.send(8'hAE);
    chk_ps(1'b0);
    // an external booster clock must not keep the booster alive in save
    ext_clk_present = 1'b1;
    u_mpu.send(8'hA5);
    chk_ps(1'b1);
    chk("force_on", 8'h01, {7'h00, pixel_force_on});
    chk("contrast", 8'h0A, {4'h0, contrast_step_register});
    chk("seg_reverse", 8'h01, {7'h00, pwr.seg_reverse});
    u_mpu.send(8'h83);
    chk("contrast", 8'h03, {4'h0, contrast_step_register});
    chk_ps(1'b1);
    u_mpu.send(8'hA4);
    chk_ps(1'b0);
    chk("booster_en", 8'h01, {7'h00, pwr.booster_en});
    u_mpu.send(8'hAF);
    u_mpu.send(8'hA5);
    chk_ps(1'b0);
    chk("force_on", 8'h01, {7'h00, pixel_force_on});
    u_mpu.send(8'hAE);
    chk_ps(1'b1);
    u_mpu.send(8'hA4);
    chk_ps(1'b0);
    chk("force_on", 8'h00, {7'h00, pixel_force_on});
    u_mpu.send(8'hAF);
    $display("power save done");
  endtask
  // outputs on, kept across a power save, then off and supply off
  task automatic t_drive;
    u_mpu.send(8'h2D);
    chk("drive_en", 8'h01, {7'h00, pwr.drive_en});
    chk("outputs_vdd", 8'h00, {7'h00, pwr.outputs_vdd});
    u_mpu.send(8'hAE);
    u_mpu.send(8'hA5);
    chk_ps(1'b1);
    u_mpu.send(8'hA4);
    chk("drive_en", 8'h01, {7'h00, pwr.drive_en});
    u_mpu.send(8'h2C);
    chk("drive_en", 8'h00, {7'h00, pwr.drive_en});
    chk("outputs_vdd", 8'h01, {7'h00, pwr.outputs_vdd});
    u_mpu.send(8'h24);
    chk("supply_en", 8'h00, {7'h00, pwr.supply_en});
    chk("booster_en", 8'h00, {7'h00, pwr.booster_en});
    ext_clk_present = 1'b0;
    $display("driver outputs done");
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    failures = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    ext_clk_present = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    t_reset();
    t_contrast();
    t_adc();
    t_save();
    t_drive();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
